// [lfc_tag_ctrl.sv]
// Purpose: protocol controller of a passive low frequency tag
// Assumes: field clock and gap detector come from the analog front end
// Notes: EEPROM contents survive the reset command, not RESETN_I
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "lfc_cfg.svh"
module lfc_tag_ctrl
    import lfc_pkg::*;
#(
    parameter int PROG_TIME_CYC = `LFC_PROG_TIME_US * `LFC_CLK_MHZ,
    parameter logic [127:0] USER_INIT = 128'h0000_0000_0000_0000_0000_0000_0000_0000
)
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    // analog front end
    input wire logic FIELD_CLK_I,
    input wire logic FIELD_GAP_I,
    input wire logic VERIFY_FAIL_I,
    output logic LOAD_MOD_O,
    output logic PROG_BUSY_O,
    // register port
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O
);

    localparam int STEP_CYC = PROG_TIME_CYC / `LFC_PROG_STEPS;

    initial begin
        if (STEP_CYC < 1 || STEP_CYC >= (1 << 20)) begin
            $error("PROG_TIME_CYC out of range");
        end
    end

    // ****************************************
    // state and memory
    // ****************************************
    lfc_state_s s;
    lfc_state_s n;
    logic [7:0] mem [`LFC_MEM_BYTES];
    logic tick;
    logic mem_we;
    logic [7:0] mem_wd;
    logic [7:0] mem_q;
    logic [7:0] mem_p;
    logic ubit;
    logic locked;
    logic [4:0] addr5;

    lfc_dl_if dl ();

    lfc_gap_decoder u_dec (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESETN_I),
        .dl(dl)
    );

    assign LOAD_MOD_O = s.mod;
    assign PROG_BUSY_O = s.prog_busy;
    assign RDATA_O = s.rdata;
    assign dl.field_tick = tick;
    assign dl.gap = s.gap_s[1];
    assign dl.enable = (s.phase != PH_LOAD) && (s.phase != PH_PROG);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [4:0] lfc_last(input logic [7:0] cfg);
        return cfg[`LFC_IDLEN_POS] ? 5'(`LFC_LAST_128) : 5'(`LFC_LAST_64);
    endfunction

    function automatic logic [4:0] lfc_lock(input logic [7:0] cfg);
        return cfg[`LFC_LOCK_HI:`LFC_LOCK_LO];
    endfunction

    function automatic lfc_state_s lfc_enter(input lfc_state_s x, input lfc_rd_e r,
                                             input logic [4:0] f, input logic [4:0] l);
        x.phase = PH_READ;
        x.rd = r;
        x.first_b = f;
        x.last_b = l;
        x.byte_p = f;
        x.bit_p = 3'h0;
        x.lead = 1'b1;
        x.hcnt = 6'h00;
        x.lvl = 1'b0;
        return x;
    endfunction

    function automatic lfc_state_s lfc_default(input lfc_state_s x);
        if (lfc_lock(x.cfg) == `LFC_LOCK_ON) begin
            return lfc_enter(x, RD_REG, 5'h00, lfc_last(x.cfg));
        end
        // unassigned lock patterns also fall back to the dummy frame
        return lfc_enter(x, RD_DUMMY, 5'h00, lfc_last(x.cfg));
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = s;
        tick = s.fclk[1] & ~s.fclk[2];
        n.fclk = {s.fclk[1:0], FIELD_CLK_I};
        n.gap_s = {s.gap_s[0], FIELD_GAP_I};
        n.vf_s = {s.vf_s[0], VERIFY_FAIL_I};
        mem_we = 1'b0;
        mem_wd = 8'h00;
        mem_q = mem[s.byte_p];
        mem_p = mem[s.pa];
        locked = lfc_lock(s.cfg) != `LFC_LOCK_OPEN;
        addr5 = 5'h00;
        if (s.rd == RD_DUMMY) begin
            ubit = {s.byte_p, s.bit_p} < 8'(`LFC_HDR_BITS);
        end else begin
            ubit = mem_q[3'h7 - s.bit_p];
        end

        n.rdata = 32'h0000_0000;
        if (RD_I) begin
            case (ADDR_I)
                `LFC_REG_MODE: n.rdata = {24'h00_0000, s.cfg};
                `LFC_REG_STATUS: n.rdata = {24'h00_0000, s.prog_busy, s.cmd_err,
                                            1'b0, s.rd, s.phase};
                `LFC_REG_CTRL: n.rdata = {31'h0000_0000, s.quiet};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
        if (WR_I && ADDR_I == `LFC_REG_CTRL) begin
            n.quiet = WDATA_I[`LFC_CTRL_QUIET];
        end

        case (s.phase)
            PH_LOAD: begin
                if (tick) begin
                    if (s.fcnt == 7'(`LFC_LOAD_FCLK - 1)) begin
                        n.cfg = mem[`LFC_CFG_ADDR];
                        n = lfc_default(n);
                    end else begin
                        n.fcnt = s.fcnt + 7'h01;
                    end
                end
            end
            PH_READ: begin
                if (tick) begin
                    n.cfg = mem[`LFC_CFG_ADDR];
                    n.hcnt = s.hcnt + 6'h01;
                    // first half carries the inverse, so a zero falls at mid-bit
                    if (s.hcnt == 6'h00) begin
                        n.lvl = s.lead ? 1'b1 : ~ubit;
                    end else if (s.hcnt == 6'(`LFC_HALF_FCLK)) begin
                        n.lvl = s.lead ? 1'b0 : ubit;
                    end
                    if (s.hcnt == 6'(`LFC_BIT_FCLK - 1)) begin
                        if (s.lead) begin
                            n.lead = 1'b0;
                        end else if (s.bit_p == 3'h7) begin
                            n.bit_p = 3'h0;
                            n.byte_p = (s.byte_p == s.last_b) ? s.first_b : s.byte_p + 5'h01;
                        end else begin
                            n.bit_p = s.bit_p + 3'h1;
                        end
                    end
                end
            end
            PH_RX: begin
                if (dl.bit_stb) begin
                    n.sh = {s.sh[14:0], dl.bit_val};
                    n.nbits = (s.nbits == 5'h1F) ? s.nbits : s.nbits + 5'h01;
                end
                if (dl.done) begin
                    n.cmd_err = 1'b0;
                    if (dl.err) begin
                        n.cmd_err = 1'b1;
                        n = lfc_default(n);
                    end else if (s.nbits == 5'd2 && s.sh[1:0] == 2'b00) begin
                        n = '0;
                        n.fclk = s.fclk;
                        n.gap_s = s.gap_s;
                        n.vf_s = s.vf_s;
                        n.quiet = s.quiet;
                        n.phase = PH_LOAD;
                    end else if (s.nbits == 5'd2 && s.sh[1:0] == 2'b10) begin
                        n = lfc_enter(n, RD_REG, 5'h00, lfc_last(s.cfg));
                    end else if (s.nbits == 5'd2 && s.sh[1:0] == 2'b11) begin
                        if (s.cfg[`LFC_IDLEN_POS]) begin
                            n = lfc_enter(n, RD_REG, 5'h00, lfc_last(s.cfg));
                        end else begin
                            n = lfc_enter(n, RD_UPPER, 5'(`LFC_UPPER_FIRST), 5'(`LFC_LAST_128));
                        end
                    end else if (s.nbits == 5'd8 && s.sh[7:5] == 3'b100
                                 && s.sh[4:0] <= 5'(`LFC_CFG_ADDR)) begin
                        addr5 = s.sh[4:0];
                        n = lfc_enter(n, RD_BYTE, addr5, addr5);
                    end else if (s.nbits == 5'd16 && s.sh[15:13] == 3'b100
                                 && s.sh[4:0] <= 5'(`LFC_CFG_ADDR)) begin
                        addr5 = s.sh[4:0];
                        if (locked) begin
                            n = lfc_enter(n, RD_BYTE, addr5, addr5);
                        end else begin
                            n.phase = PH_PROG;
                            n.step = PS_ERASE;
                            n.pcnt = 20'h0_0000;
                            n.pa = addr5;
                            n.pd = s.sh[12:5];
                            n.prog_busy = 1'b1;
                        end
                    end else begin
                        n.cmd_err = 1'b1;
                        n = lfc_default(n);
                    end
                end
            end
            PH_PROG: begin
                if (s.pcnt == 20'(STEP_CYC - 1)) begin
                    n.pcnt = 20'h0_0000;
                    case (s.step)
                        PS_ERASE: begin
                            mem_we = 1'b1;
                            mem_wd = 8'h00;
                            n.step = PS_EVER;
                        end
                        PS_EVER: begin
                            if (mem_p != 8'h00 || s.vf_s[1]) begin
                                n.phase = PH_MUTE;
                                n.prog_busy = 1'b0;
                            end else begin
                                n.step = PS_WRITE;
                            end
                        end
                        PS_WRITE: begin
                            mem_we = 1'b1;
                            mem_wd = s.pd;
                            n.step = PS_PVER;
                        end
                        PS_PVER: begin
                            n.prog_busy = 1'b0;
                            if ((mem_p & s.pd) != s.pd || s.vf_s[1]) begin
                                n.phase = PH_MUTE;
                            end else begin
                                n = lfc_enter(n, RD_BYTE, s.pa, s.pa);
                            end
                        end
                        default: n.step = PS_ERASE;
                    endcase
                end else begin
                    n.pcnt = s.pcnt + 20'h0_0001;
                end
            end
            PH_MUTE: begin
                n.lvl = 1'b0;
            end
            default: n.phase = PH_LOAD;
        endcase

        if (dl.start) begin
            n.phase = PH_RX;
            n.sh = 16'h0000;
            n.nbits = 5'h00;
        end
        n.mod = (n.phase == PH_READ) && !n.quiet && n.lvl;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ****************************************
    // eeprom array
    // ****************************************
    // only a power-on reset restores delivery contents; the reset command keeps them
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            for (int i = 0; i < `LFC_CFG_ADDR; i++) begin
                mem[i] <= USER_INIT[127 - 8 * i -: 8];
            end
            mem[`LFC_CFG_ADDR] <= `LFC_CFG_RESET;
        end else if (mem_we) begin
            mem[s.pa] <= mem_wd;
        end
    end

endmodule
`default_nettype wire

// [lfc_cfg.svh]
// Purpose: constants of the tag protocol controller
// Assumes: field clock counts are in field clock periods
// Notes: definitions only
`ifndef LFC_CFG_SVH
`define LFC_CFG_SVH

// ****************************************
// timing counts
// ****************************************
`define LFC_LOAD_FCLK 98
`define LFC_ZERO_MIN 18
`define LFC_ZERO_MAX 33
`define LFC_ONE_MIN 50
`define LFC_ONE_MAX 65
`define LFC_TIMEOUT_FCLK 64
`define LFC_BIT_FCLK 64
`define LFC_HALF_FCLK 32
`define LFC_PROG_TIME_US 5600
`define LFC_CLK_MHZ 10
`define LFC_PROG_STEPS 4

// ****************************************
// memory layout and field positions
// ****************************************
`define LFC_CFG_ADDR 16
`define LFC_MEM_BYTES 17
`define LFC_LOCK_HI 7
`define LFC_LOCK_LO 3
`define LFC_IDLEN_POS 0
`define LFC_LOCK_ON 5'h0D
`define LFC_LOCK_OPEN 5'h00
`define LFC_HDR_BITS 9
`define LFC_LAST_64 7
`define LFC_LAST_128 15
`define LFC_UPPER_FIRST 8
`define LFC_CFG_RESET 8'h06

// ****************************************
// register port
// ****************************************
`define LFC_REG_MODE 8'h00
`define LFC_REG_STATUS 8'h04
`define LFC_REG_CTRL 8'h08
`define LFC_CTRL_QUIET 0

`endif

// [lfc_pkg.sv]
// Purpose: types of the tag protocol controller
// Assumes: constants come from lfc_cfg.svh
// Notes: state structs of both modules
package lfc_pkg;

    typedef enum logic [2:0] {PH_LOAD, PH_READ, PH_RX, PH_PROG, PH_MUTE} lfc_phase_e;
    typedef enum logic [1:0] {RD_REG, RD_UPPER, RD_BYTE, RD_DUMMY} lfc_rd_e;
    typedef enum logic [1:0] {PS_ERASE, PS_EVER, PS_WRITE, PS_PVER} lfc_pstep_e;
    typedef enum logic {DS_IDLE, DS_RX} lfc_dstate_e;

    typedef struct packed {
        logic [2:0] fclk;
        logic [1:0] gap_s;
        logic [1:0] vf_s;
        lfc_phase_e phase;
        lfc_rd_e rd;
        lfc_pstep_e step;
        logic [7:0] cfg;
        logic [6:0] fcnt;
        logic [4:0] first_b;
        logic [4:0] last_b;
        logic [4:0] byte_p;
        logic [2:0] bit_p;
        logic lead;
        logic [5:0] hcnt;
        logic lvl;
        logic mod;
        logic [15:0] sh;
        logic [4:0] nbits;
        logic [19:0] pcnt;
        logic [4:0] pa;
        logic [7:0] pd;
        logic quiet;
        logic cmd_err;
        logic prog_busy;
        logic [31:0] rdata;
    } lfc_state_s;

    typedef struct packed {
        lfc_dstate_e st;
        logic gap_d;
        logic [6:0] cnt;
        logic err;
        logic start;
        logic stb;
        logic bitv;
        logic done;
    } lfc_dec_s;

endpackage

// [lfc_dl_if.sv]
// Purpose: carrier between controller and gap decoder
// Assumes: one core clock for both ends
// Notes: strobes are one cycle long
`timescale 1ns/1ps
`default_nettype none
interface lfc_dl_if;
    logic field_tick;
    logic gap;
    logic enable;
    logic start;
    logic bit_stb;
    logic bit_val;
    logic done;
    logic err;

    modport dec (input field_tick, input gap, input enable,
                 output start, output bit_stb, output bit_val, output done, output err);
    modport ctl (output field_tick, output gap, output enable,
                 input start, input bit_stb, input bit_val, input done, input err);
endinterface
`default_nettype wire

// [lfc_gap_decoder.sv]
// Purpose: pulse interval decoding of reader gaps
// Assumes: gap level already synchronised, field_tick one core cycle
// Notes: spacing is counted in field clocks, which stop during a gap
`timescale 1ns/1ps
`default_nettype none
`include "lfc_cfg.svh"
module lfc_gap_decoder
    import lfc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // controller side
    lfc_dl_if.dec dl
);

    lfc_dec_s s;
    lfc_dec_s n;
    logic gap_rise;

    assign dl.start = s.start;
    assign dl.bit_stb = s.stb;
    assign dl.bit_val = s.bitv;
    assign dl.done = s.done;
    assign dl.err = s.err;

    always_comb begin
        n = s;
        n.start = 1'b0;
        n.stb = 1'b0;
        n.done = 1'b0;
        n.gap_d = dl.gap;
        gap_rise = dl.gap & ~s.gap_d;
        case (s.st)
            DS_IDLE: begin
                if (dl.enable && gap_rise) begin
                    n.st = DS_RX;
                    n.cnt = 7'h00;
                    n.err = 1'b0;
                    n.start = 1'b1;
                end
            end
            DS_RX: begin
                if (gap_rise) begin
                    if (s.cnt >= 7'(`LFC_ZERO_MIN) && s.cnt <= 7'(`LFC_ZERO_MAX)) begin
                        n.stb = 1'b1;
                        n.bitv = 1'b0;
                    end else if (s.cnt >= 7'(`LFC_ONE_MIN) && s.cnt <= 7'(`LFC_ONE_MAX)) begin
                        n.stb = 1'b1;
                        n.bitv = 1'b1;
                    end else begin
                        n.err = 1'b1;
                    end
                    n.cnt = 7'h00;
                end else if (dl.field_tick) begin
                    // a valid one may still close at the top of its window
                    if (s.cnt == 7'(`LFC_ONE_MAX)) begin
                        n.done = 1'b1;
                        n.st = DS_IDLE;
                    end else begin
                        n.cnt = s.cnt + 7'h01;
                    end
                end
            end
            default: n.st = DS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

endmodule
`default_nettype wire

// [lfc_tag_ctrl_monitor.sv]
// Purpose: port checker of the tag protocol controller
// Assumes: programming time parameter matches the bound instance
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module lfc_tag_ctrl_monitor #(
    parameter int PROG_TIME_CYC = 40
)
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    // front end
    input wire logic FIELD_CLK_I,
    input wire logic FIELD_GAP_I,
    input wire logic VERIFY_FAIL_I,
    input wire logic LOAD_MOD_O,
    input wire logic PROG_BUSY_O,
    // register port
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O
);
    // ****************************************
    // helper counters
    // ****************************************
    logic mod_q;
    logic [8:0] hold;
    logic [9:0] up;
    logic [9:0] calm;
    logic [15:0] busy;
    always_ff @(posedge CORE_CLK_I) begin
        mod_q <= LOAD_MOD_O;
        if (!RESETN_I) begin
            hold <= 9'h1FF;
            up <= 10'h000;
            calm <= 10'h000;
            busy <= 16'h0000;
        end else begin
            hold <= (mod_q != LOAD_MOD_O) ? 9'h000 : hold + {8'h00, hold != 9'h1FF};
            up <= up + {9'h000, up != 10'h3FF};
            calm <= FIELD_GAP_I ? 10'h000 : calm + {9'h000, calm != 10'h3FF};
            busy <= PROG_BUSY_O ? busy + 16'h0001 : 16'h0000;
        end
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);

    property p_load_len;
        $rose(LOAD_MOD_O) |-> up >= 10'h302;
    endproperty
    a_load_len: assert property (p_load_len)
        else $error("modulation before the mode register load ended");
    property p_gap_off;
        FIELD_GAP_I [*6] |-> !LOAD_MOD_O;
    endproperty
    a_gap_off: assert property (p_gap_off)
        else $error("modulation kept up during a field gap");
    property p_half_bit;
        $rose(LOAD_MOD_O) |-> hold >= 9'h0FA;
    endproperty
    a_half_bit: assert property (p_half_bit)
        else $error("modulation half bit shorter than 32 field clocks");
    property p_busy_len;
        $fell(PROG_BUSY_O) && !VERIFY_FAIL_I |-> busy >= PROG_TIME_CYC && busy <= PROG_TIME_CYC + 4;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("programming cycle of wrong length");
    // a fault at the erase check ends the cycle after two of four steps
    property p_busy_short;
        $fell(PROG_BUSY_O) && VERIFY_FAIL_I |-> busy >= PROG_TIME_CYC / 2 && busy <= PROG_TIME_CYC / 2 + 4;
    endproperty
    a_busy_short: assert property (p_busy_short)
        else $error("failed programming cycle of wrong length");
    property p_busy_off;
        PROG_BUSY_O |-> !LOAD_MOD_O;
    endproperty
    a_busy_off: assert property (p_busy_off)
        else $error("modulation during programming");
    property p_mute;
        $fell(PROG_BUSY_O) && VERIFY_FAIL_I |-> (!LOAD_MOD_O) [*8];
    endproperty
    a_mute: assert property (p_mute)
        else $error("modulation after a failed verify");
    property p_exec_late;
        $rose(PROG_BUSY_O) |-> calm >= 10'h200;
    endproperty
    a_exec_late: assert property (p_exec_late)
        else $error("command run before the reception timeout");
    property p_rdata_one;
        !$past(RD_I) |-> RDATA_O == 32'h0000_0000;
    endproperty
    a_rdata_one: assert property (p_rdata_one)
        else $error("read data outside its cycle");
endmodule
bind lfc_tag_ctrl lfc_tag_ctrl_monitor #(.PROG_TIME_CYC(PROG_TIME_CYC)) mon (
    .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .FIELD_CLK_I(FIELD_CLK_I),
    .FIELD_GAP_I(FIELD_GAP_I), .VERIFY_FAIL_I(VERIFY_FAIL_I), .LOAD_MOD_O(LOAD_MOD_O),
    .PROG_BUSY_O(PROG_BUSY_O), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O));
`default_nettype wire

// [lfc_reader_model.sv]
// Purpose: reader base station gapping the field
// Assumes: field clock of 800 ns
// Notes: spacings drawn at random inside the accepted windows
`timescale 1ns/1ps
`default_nettype none
module lfc_reader_model (
    // field towards the tag
    output logic FIELD_CLK_O,
    output logic FIELD_GAP_O
);
    initial begin
        FIELD_CLK_O = 1'b0;
        FIELD_GAP_O = 1'b0;
    end
    // no field, no clock: it stands low through a gap
    always begin
        #400;
        FIELD_CLK_O = FIELD_GAP_O ? 1'b0 : ~FIELD_CLK_O;
    end
    task automatic gap(input int fc);
        FIELD_GAP_O = 1'b1;
        #(fc * 800);
        FIELD_GAP_O = 1'b0;
    endtask
    // bit index bad gets a spacing that is neither zero nor one
    task automatic send(input logic [15:0] bits, input int n, input int bad);
        int s;
        gap(15);
        for (int i = n - 1; i >= 0; i--) begin
            s = bits[i] ? 52 + $urandom % 12 : 20 + $urandom % 12;
            repeat (i == bad ? 40 : s) @(posedge FIELD_CLK_O);
            gap(10);
        end
    endtask
endmodule
`default_nettype wire

// [lf_tag_protocol_controller_test.sv]
// Purpose: self-checking bench of the tag protocol controller
// Assumes: short programming time, known memory image
// Notes: uplink decoded by sampling each half bit
`timescale 1ns/1ps
`default_nettype none
`include "lfc_cfg.svh"
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module lf_tag_protocol_controller_test;
    import lfc_pkg::*;
    localparam logic [127:0] INIT = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic vfail = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fclk, fgap, lmod, busy;
    logic [31:0] rdata;
    logic [7:0] mem [0:16];
    int num_errors = 0;
    int comparisons = 0;
    int prog_runs = 0;
    always #50 clk = ~clk;
    always @(posedge busy) prog_runs++;

    lfc_tag_ctrl #(.PROG_TIME_CYC(40), .USER_INIT(INIT)) uut (
        .CORE_CLK_I(clk), .RESETN_I(rst_n), .FIELD_CLK_I(fclk), .FIELD_GAP_I(fgap),
        .VERIFY_FAIL_I(vfail), .LOAD_MOD_O(lmod), .PROG_BUSY_O(busy), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
    lfc_reader_model rdr (.FIELD_CLK_O(fclk), .FIELD_GAP_O(fgap));

    // ****************************************
    // tasks
    // ****************************************
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic status(input logic err, input lfc_rd_e k, input lfc_phase_e p);
        logic [31:0] s;
        reg_rd(`LFC_REG_STATUS, s);
        `CHK({s[6], s[4:0]}, {err, k, p})
    endtask
    // must start before read entry: syncs on the leading zero's high half
    task automatic uplink(input int n, input logic [127:0] exp);
        logic a;
        int k;
        for (k = 0; k < 3000 && lmod !== 1'b1; k++) @(posedge clk);
        if (k == 3000) begin
            num_errors++;
            $display("unexpected at %0t: no uplink start", $time);
        end
        for (int i = n - 1; i >= 0; i--) begin
            repeat (16) @(posedge fclk);
            a = lmod;
            repeat (32) @(posedge fclk);
            `CHK({a, lmod}, {~exp[i], exp[i]})
            repeat (16) @(posedge fclk);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial begin : main
        logic [31:0] d;
        logic [7:0] wd;
        logic [4:0] wa;
        void'($urandom(32'h0114));
        for (int i = 0; i < 16; i++) mem[i] = INIT[127 - 8 * i -: 8];
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // mode register holds zero until the 98 field clock load is over
        uplink(12, {1'b0, 9'h1FF, 2'h0});
        reg_rd(`LFC_REG_MODE, d);
        `CHK(d, {24'h00_0000, `LFC_CFG_RESET})
        status(1'b0, RD_DUMMY, PH_READ);
        reg_wr(`LFC_REG_CTRL, 32'h0000_0001);
        reg_rd(8'h0C, d);
        `CHK(d, 32'h0000_0000)
        repeat (40) @(posedge fclk);
        `CHK(lmod, 1'b0)
        reg_rd(`LFC_REG_CTRL, d);
        `CHK(d, 32'h0000_0001)
        reg_wr(`LFC_REG_CTRL, 32'h0000_0000);
        rdr.send({8'h00, 3'h4, 5'h03}, 8, -1);
        uplink(17, {1'b0, mem[3], mem[3]});
        status(1'b0, RD_BYTE, PH_READ);
        wd = 8'($urandom);
        wa = 5'($urandom % 16);
        rdr.send({3'h4, wd, wa}, 16, -1);
        mem[wa] = wd;
        uplink(9, {1'b0, wd});
        rdr.send(16'h0002, 2, -1);
        uplink(9, {1'b0, mem[0]});
        status(1'b0, RD_REG, PH_READ);
        rdr.send(16'h0004, 3, -1);
        repeat (90) @(posedge fclk);
        status(1'b1, RD_DUMMY, PH_READ);
        rdr.send(16'h0003, 2, -1);
        uplink(9, {1'b0, mem[8]});
        status(1'b0, RD_UPPER, PH_READ);
        rdr.send(16'h0002, 2, 0);
        repeat (90) @(posedge fclk);
        status(1'b1, RD_DUMMY, PH_READ);
        @(posedge clk);
        vfail <= 1'b1;
        rdr.send({3'h4, 8'hA5, 5'h09}, 16, -1);
        repeat (90) @(posedge fclk);
        reg_rd(`LFC_REG_STATUS, d);
        `CHK(d[2:0], PH_MUTE)
        `CHK(lmod, 1'b0)
        @(posedge clk);
        vfail <= 1'b0;
        rdr.send({3'h4, 8'h6E, 5'h10}, 16, -1);
        uplink(9, {1'b0, 8'h6E});
        rdr.send(16'h0000, 2, -1);
        uplink(17, {1'b0, mem[0], mem[1]});
        reg_rd(`LFC_REG_MODE, d);
        `CHK(d, 32'h0000_006E)
        status(1'b0, RD_REG, PH_READ);
        rdr.send({3'h4, ~mem[2], 5'h02}, 16, -1);
        uplink(9, {1'b0, mem[2]});
        `CHK(prog_runs, 3)
        close_out();
    end
    initial begin : watchdog
        repeat (100000) @(posedge clk);
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
